/* File: core/nprs_busy_timer.v */
// Purpose: down-counter timing array read and cache busy periods
// Assumes: load pulse starts a period; done pulses once at its end
// Notes:   a new load restarts the count
`timescale 1ns/1ns
module nprs_busy_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_n_i,
  // control
  input  wire             load_i,
  input  wire [WIDTH-1:0] count_i,
  // status
  output reg              busy_o,
  output reg              done_o
);
  reg [WIDTH-1:0] remain;

  // count down, flag the final cycle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= {WIDTH{1'b0}};
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        remain <= count_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* File: core/nprs_plane_regs.v */
// Purpose: per-plane page pointers for data and cache registers
// Assumes: one pointer pair per plane, updated by strobes
// Notes:   cache pointer names the page now held in the cache register
`timescale 1ns/1ns
module nprs_plane_regs #(
  parameter PLANES = 2,
  parameter ROW_W  = 24
) (
  // clock and reset
  input  wire                    clk_i,
  input  wire                    rst_n_i,
  // update strobes
  input  wire [PLANES-1:0]       load_data_i,
  input  wire [ROW_W-1:0]        row_i,
  input  wire [PLANES-1:0]       seq_i,
  input  wire [PLANES-1:0]       data_to_cache_i,
  // contents
  output wire [PLANES*ROW_W-1:0] cache_rows_o
);
  genvar p;
  generate
    for (p = 0; p < PLANES; p = p + 1) begin : g_plane
      reg [ROW_W-1:0] data_row;
      reg [ROW_W-1:0] cache_row;
      // load wins over increment; copy then takes the old data page
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          data_row  <= {ROW_W{1'b0}};
          cache_row <= {ROW_W{1'b0}};
        end else begin
          if (data_to_cache_i[p])
            cache_row <= data_row;
          if (load_data_i[p])
            data_row <= row_i;
          else if (seq_i[p])
            data_row <= data_row + {{(ROW_W-1){1'b0}}, 1'b1};
        end
      end
      assign cache_rows_o[p*ROW_W +: ROW_W] = cache_row;
    end
  endgenerate
endmodule

/* File: core/nprs_read_seq.v */
// Purpose: page, cache and multi-plane read command sequencing of one die
// Assumes: one command or address byte per strobe, synchronous to clk_i
// Notes:   array contents are not modelled; only pointers and status
// What this block does
// - page read alone loads the plane's cache register and enables output
// - sequential cache read loads the next page into the data register
// - random cache read loads the given page of any plane into data register
// - after a cache read command, busy low and both ready bits clear
// - after cache busy, pin high, lun ready, array busy, column zero
// - change read column moves the output column during cache output
// - cache-read-last: busy, then fully ready with column zero; data copied to cache a cycle later
// - multi-plane pairs load each plane's data register at its 32h; all planes copy to cache together
// - enhanced change read column selects the plane driving output
// - multi-plane sequential cache read advances every addressed plane
// - read mode ends status output and resumes data output
// - read mode accepted when ready or while only array busy
// - multi-plane cache-read-last goes ready, then copies the data register of every addressed plane a cycle later
// - random cache read ignores the column and uses the row only
`timescale 1ns/1ns
`include "nprs_regs.vh"
module nprs_read_seq #(
  parameter PLANES        = 2,
  parameter PLANE_W       = 1,
  parameter ROW_W         = 24,
  parameter COL_W         = 16,
  parameter TMR_W         = 16,
  parameter ARRAY_READ_CY = `NPRS_ARRAY_READ_CYC,
  parameter CACHE_BUSY_CY = `NPRS_CACHE_BUSY_CYC
) (
  // clock and reset
  input  wire                    clk_i,
  input  wire                    reset_n_i,
  // host bus cycles
  input  wire                    cmd_we_i,
  input  wire                    addr_we_i,
  input  wire [7:0]              dq_i,
  // status pin and bits
  output reg                     ready_busy_n_o,
  output reg                     lun_ready_o,
  output reg                     array_ready_bit_o,
  // output path
  output reg                     data_out_en_o,
  output reg                     status_out_en_o,
  output reg [PLANE_W-1:0]       out_plane_o,
  output reg [COL_W-1:0]         out_col_o,
  output reg [ROW_W-1:0]         out_row_o,
  output reg                     cmd_reject_o
);
  // command states
  localparam ST_IDLE   = 3'd0;
  localparam ST_ADDR   = 3'd1;
  localparam ST_CONF   = 3'd2;
  localparam ST_COL    = 3'd3;
  // op codes held while address cycles arrive
  localparam OP_READ   = 2'd0;
  localparam OP_COL    = 2'd1;
  localparam OP_COLENH = 2'd2;
  // array modes
  localparam M_READY   = 2'd0;
  localparam M_ARRAY   = 2'd1;
  localparam M_CBUSY   = 2'd2;
  localparam M_CACHE   = 2'd3;

  reg  [1:0]              rst_sync;
  wire                    rst_n = rst_sync[1];
  reg  [2:0]              state;
  reg  [1:0]              op;
  reg  [2:0]              acnt;
  reg  [39:0]             abuf;
  reg  [1:0]              mode;
  reg                     last_pending;
  reg  [PLANES-1:0]       mp_mask;
  reg  [PLANES-1:0]       active_mask;
  reg                     tmr_load;
  reg  [TMR_W-1:0]        tmr_count;
  wire                    tmr_busy;
  wire                    tmr_done;
  reg  [PLANES-1:0]       load_data;
  reg  [PLANES-1:0]       seq_step;
  reg  [PLANES-1:0]       to_cache;
  reg  [ROW_W-1:0]        load_row;
  wire [PLANES*ROW_W-1:0] cache_rows;

  // plane field sits in the low row bits
  function [PLANE_W-1:0] plane_of;
    input [39:0] a;
    plane_of = a[16 +: PLANE_W];
  endfunction

  function [PLANES-1:0] onehot;
    input [PLANE_W-1:0] p;
    onehot = {{(PLANES-1){1'b0}}, 1'b1} << p;
  endfunction

  // release reset through two flops
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  nprs_busy_timer #(.WIDTH(TMR_W)) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .busy_o  (tmr_busy),
    .done_o  (tmr_done)
  );

  nprs_plane_regs #(.PLANES(PLANES), .ROW_W(ROW_W)) u_planes (
    .clk_i           (clk_i),
    .rst_n_i         (rst_n),
    .load_data_i     (load_data),
    .row_i           (load_row),
    .seq_i           (seq_step),
    .data_to_cache_i (to_cache),
    .cache_rows_o    (cache_rows)
  );

  wire cmd_now   = cmd_we_i;
  wire is_reset  = cmd_now && (dq_i == `NPRS_CMD_RESET || dq_i == `NPRS_CMD_SYNC_RESET);
  wire is_status = cmd_now && (dq_i == `NPRS_CMD_STATUS || dq_i == `NPRS_CMD_STATUS_ENH);
  wire full_rdy  = (mode == M_READY);
  wire cache_rdy = (mode == M_CACHE);
  wire in_busy   = (mode == M_ARRAY) || (mode == M_CBUSY);
  wire [PLANE_W-1:0] a_plane = plane_of(abuf);

  // command decode and sequencing
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state             <= ST_IDLE;
      op                <= OP_READ;
      acnt              <= 3'd0;
      abuf              <= 40'h0000000000;
      mode              <= M_READY;
      last_pending      <= 1'b0;
      mp_mask           <= {PLANES{1'b0}};
      active_mask       <= {{(PLANES-1){1'b0}}, 1'b1};
      tmr_load          <= 1'b0;
      tmr_count         <= {TMR_W{1'b0}};
      load_data         <= {PLANES{1'b0}};
      seq_step          <= {PLANES{1'b0}};
      to_cache          <= {PLANES{1'b0}};
      load_row          <= {ROW_W{1'b0}};
      ready_busy_n_o    <= 1'b1;
      lun_ready_o       <= 1'b1;
      array_ready_bit_o <= 1'b1;
      data_out_en_o     <= 1'b0;
      status_out_en_o   <= 1'b0;
      out_plane_o       <= {PLANE_W{1'b0}};
      out_col_o         <= `NPRS_COL_RESET;
      out_row_o         <= {ROW_W{1'b0}};
      cmd_reject_o      <= 1'b0;
    end else begin
      tmr_load     <= 1'b0;
      load_data    <= {PLANES{1'b0}};
      seq_step     <= {PLANES{1'b0}};
      to_cache     <= {PLANES{1'b0}};
      cmd_reject_o <= 1'b0;
      out_row_o    <= cache_rows[out_plane_o*ROW_W +: ROW_W];
      // end of a busy period
      if (tmr_done) begin
        ready_busy_n_o <= 1'b1;
        lun_ready_o    <= 1'b1;
        if (mode == M_CBUSY && !last_pending) begin
          mode              <= M_CACHE;
          array_ready_bit_o <= 1'b0;
          out_col_o         <= `NPRS_COL_RESET;
        end else begin
          mode              <= M_READY;
          array_ready_bit_o <= 1'b1;
          if (last_pending) begin
            to_cache  <= active_mask;
            out_col_o <= `NPRS_COL_RESET;
          end
        end
        last_pending <= 1'b0;
      end
      if (is_reset) begin
        // reset aborts everything and returns to ready
        state             <= ST_IDLE;
        mode              <= M_READY;
        mp_mask           <= {PLANES{1'b0}};
        last_pending      <= 1'b0;
        ready_busy_n_o    <= 1'b1;
        lun_ready_o       <= 1'b1;
        array_ready_bit_o <= 1'b1;
        data_out_en_o     <= 1'b0;
        status_out_en_o   <= 1'b0;
        tmr_load          <= 1'b1;
        tmr_count         <= {{(TMR_W-1){1'b0}}, 1'b1};
      end else if (is_status) begin
        status_out_en_o <= 1'b1;
        data_out_en_o   <= 1'b0;
      end else if (in_busy && (cmd_we_i || addr_we_i)) begin
        cmd_reject_o <= 1'b1;
      end else if (addr_we_i && state == ST_ADDR) begin
        abuf <= {dq_i, abuf[39:8]};
        acnt <= acnt + 3'd1;
        if ((op == OP_COL && acnt == 3'd1) || acnt == 3'd`NPRS_ADDR_CYCLES - 3'd1)
          state <= ST_CONF;
      end else if (cmd_now) begin
        // a bare read mode byte leaves an empty address phase; any new command decodes afresh
        case ((state == ST_ADDR && acnt == 3'd0) ? ST_IDLE : state)
          ST_IDLE: begin
            state <= ST_IDLE;
            if (dq_i == `NPRS_CMD_READ) begin
              if (status_out_en_o && (full_rdy || cache_rdy)) begin
                status_out_en_o <= 1'b0;
                data_out_en_o   <= 1'b1;
              end
              op    <= OP_READ;
              acnt  <= 3'd0;
              state <= ST_ADDR;
            end else if (dq_i == `NPRS_CMD_CHG_COL && (full_rdy || cache_rdy)) begin
              op    <= OP_COL;
              acnt  <= 3'd0;
              state <= ST_ADDR;
            end else if (dq_i == `NPRS_CMD_CHG_COL_ENH && (full_rdy || cache_rdy)) begin
              op    <= OP_COLENH;
              acnt  <= 3'd0;
              state <= ST_ADDR;
            end else if (dq_i == `NPRS_CMD_CACHE_SEQ && (full_rdy || cache_rdy)) begin
              seq_step          <= active_mask;
              to_cache          <= active_mask; // old data page moves out before the step
              mode              <= M_CBUSY;
              ready_busy_n_o    <= 1'b0;
              lun_ready_o       <= 1'b0;
              array_ready_bit_o <= 1'b0;
              data_out_en_o     <= 1'b0;
              tmr_load          <= 1'b1;
              tmr_count         <= CACHE_BUSY_CY[TMR_W-1:0];
            end else if (dq_i == `NPRS_CMD_CACHE_LAST && (full_rdy || cache_rdy)) begin
              last_pending      <= 1'b1;
              mode              <= M_CBUSY;
              ready_busy_n_o    <= 1'b0;
              lun_ready_o       <= 1'b0;
              array_ready_bit_o <= 1'b0;
              data_out_en_o     <= 1'b0;
              tmr_load          <= 1'b1;
              tmr_count         <= CACHE_BUSY_CY[TMR_W-1:0];
            end else begin
              cmd_reject_o <= 1'b1;
            end
          end
          ST_CONF: begin
            state <= ST_IDLE;
            if (op == OP_READ && dq_i == `NPRS_CMD_MP_CONF) begin
              mp_mask   <= mp_mask | onehot(a_plane);
              load_data <= onehot(a_plane);
              load_row  <= abuf[16 +: ROW_W];
            end else if (op == OP_READ && dq_i == `NPRS_CMD_READ_CONF && full_rdy) begin
              load_data         <= onehot(a_plane); // other planes loaded at 32h
              load_row          <= abuf[16 +: ROW_W];
              active_mask       <= mp_mask | onehot(a_plane);
              mp_mask           <= {PLANES{1'b0}};
              last_pending      <= 1'b1;        // array read lands in cache
              out_plane_o       <= a_plane;
              out_col_o         <= abuf[COL_W-1:0];
              mode              <= M_ARRAY;
              ready_busy_n_o    <= 1'b0;
              lun_ready_o       <= 1'b0;
              array_ready_bit_o <= 1'b0;
              data_out_en_o     <= 1'b1;
              tmr_load          <= 1'b1;
              tmr_count         <= ARRAY_READ_CY[TMR_W-1:0];
            end else if (op == OP_READ && dq_i == `NPRS_CMD_CACHE_SEQ) begin
              load_data         <= onehot(a_plane);
              to_cache          <= active_mask; // previous pages stay readable in cache
              load_row          <= abuf[16 +: ROW_W];
              active_mask       <= mp_mask | onehot(a_plane);
              mp_mask           <= {PLANES{1'b0}};
              mode              <= M_CBUSY;
              ready_busy_n_o    <= 1'b0;
              lun_ready_o       <= 1'b0;
              array_ready_bit_o <= 1'b0;
              data_out_en_o     <= 1'b0;
              tmr_load          <= 1'b1;
              tmr_count         <= CACHE_BUSY_CY[TMR_W-1:0];
            end else if (op == OP_COL && dq_i == `NPRS_CMD_CHG_COL_CONF) begin
              out_col_o       <= abuf[39 -: COL_W];
              data_out_en_o   <= 1'b1;
              status_out_en_o <= 1'b0;
            end else if (op == OP_COLENH && dq_i == `NPRS_CMD_CHG_COL_CONF) begin
              out_plane_o     <= a_plane;
              out_col_o       <= abuf[COL_W-1:0];
              data_out_en_o   <= 1'b1;
              status_out_en_o <= 1'b0;
            end else begin
              cmd_reject_o <= 1'b1;
            end
          end
          default: begin
            state        <= ST_IDLE;
            cmd_reject_o <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

/* File: pkg/nprs_regs.vh */
// Purpose: shared constants for the nand page and cache read sequencer
// Assumes: byte-wide command/address cycles latched on clk_i
// Notes:   times in ns, cycle counts derived at 20 MHz
`ifndef NPRS_REGS_VH
`define NPRS_REGS_VH
`define NPRS_CLK_NS           50
`define NPRS_CMD_READ         8'h00
`define NPRS_CMD_READ_CONF    8'h30
`define NPRS_CMD_CACHE_SEQ    8'h31
`define NPRS_CMD_MP_CONF      8'h32
`define NPRS_CMD_CACHE_LAST   8'h3F
`define NPRS_CMD_CHG_COL      8'h05
`define NPRS_CMD_CHG_COL_ENH  8'h06
`define NPRS_CMD_CHG_COL_CONF 8'hE0
`define NPRS_CMD_STATUS       8'h70
`define NPRS_CMD_STATUS_ENH   8'h78
`define NPRS_CMD_RESET        8'hFF
`define NPRS_CMD_SYNC_RESET   8'hFC
`define NPRS_ARRAY_READ_NS    25000
`define NPRS_CACHE_BUSY_NS    3000
`define NPRS_ARRAY_READ_CYC   ((`NPRS_ARRAY_READ_NS + `NPRS_CLK_NS - 1) / `NPRS_CLK_NS)
`define NPRS_CACHE_BUSY_CYC   ((`NPRS_CACHE_BUSY_NS + `NPRS_CLK_NS - 1) / `NPRS_CLK_NS)
`define NPRS_ADDR_CYCLES      5
`define NPRS_COL_RESET        16'h0000
`endif

/* File: verification/nand_page_and_cache_read_sequencer_tb_top.sv */
// Purpose: self-checking bench of the read sequencer
// Assumes: host model drives bytes; bench drives reset on falling edges
// Notes:   short busy counts keep the run brief
`timescale 1ns/1ns
module nand_page_and_cache_read_sequencer_tb_top;
  localparam ARR_CY = 8;
  localparam CB_CY  = 6;
  logic        clk_i, reset_n_i, cmd_we_i, addr_we_i;
  logic [7:0]  dq_i;
  logic        ready_busy_n_o, lun_ready_o, array_ready_bit_o;
  logic        data_out_en_o, status_out_en_o, cmd_reject_o;
  logic [0:0]  out_plane_o;
  logic [15:0] out_col_o;
  logic [23:0] out_row_o;
  int          fails, compares, cycles;
  nprs_read_seq #(.ARRAY_READ_CY(ARR_CY), .CACHE_BUSY_CY(CB_CY)) i_nprs_read_seq (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_we_i(cmd_we_i), .addr_we_i(addr_we_i), .dq_i(dq_i),
    .ready_busy_n_o(ready_busy_n_o), .lun_ready_o(lun_ready_o), .array_ready_bit_o(array_ready_bit_o),
    .data_out_en_o(data_out_en_o), .status_out_en_o(status_out_en_o), .out_plane_o(out_plane_o),
    .out_col_o(out_col_o), .out_row_o(out_row_o), .cmd_reject_o(cmd_reject_o));
  nprs_host_model i_nprs_host_model (.clk_i(clk_i), .cmd_we_o(cmd_we_i), .addr_we_o(addr_we_i), .dq_o(dq_i));
  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stat(input logic [2:0] e);
    chk("rb_lun_array", {ready_busy_n_o, lun_ready_o, array_ready_bit_o}, e);
  endtask
  // bounded wait for the busy pin, then two cycles for the cache copy and row lag
  task automatic wait_rb();
    int n;
    n = 0;
    while (ready_busy_n_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("ready_wait", n < 100, 1);
    repeat (2) i_nprs_host_model.rel();
  endtask
  // one command byte through the host model
  task automatic cmd(input logic [7:0] c);
    i_nprs_host_model.cmd1(c);
  endtask
  task automatic t_page();
    stat(3'b111);
    i_nprs_host_model.op5(8'h00, 16'h0000, 24'h000200, 8'h30);
    stat(3'b000);
    chk("data_out_en", data_out_en_o, 1);
    wait_rb();
    stat(3'b111);
    chk("out_row", out_row_o, 24'h000200);
    cmd(8'h70);
    chk("status_en", status_out_en_o, 1);
    cmd(8'h00);
    chk("status_en", status_out_en_o, 0);
    chk("data_out_en", data_out_en_o, 1);
  endtask
  task automatic t_rand(input logic [23:0] row, input logic [23:0] cached);
    i_nprs_host_model.op5(8'h00, 16'h1234, row, 8'h31);
    stat(3'b000);
    cmd(8'h05);
    chk("reject", cmd_reject_o, 1);
    cmd(8'h70);
    chk("reject", cmd_reject_o, 0);
    wait_rb();
    stat(3'b110);
    chk("out_col", out_col_o, 0);
    chk("out_row", out_row_o, cached);
  endtask
  task automatic t_col();
    i_nprs_host_model.col2(16'h0ABC);
    chk("out_col", out_col_o, 16'h0ABC);
    chk("data_out_en", data_out_en_o, 1);
    cmd(8'h30);
    chk("reject", cmd_reject_o, 1);
    stat(3'b110);
    cmd(8'h70);
    cmd(8'h00);
    chk("status_en", status_out_en_o, 0);
    chk("data_out_en", data_out_en_o, 1);
  endtask
  task automatic t_seq_last(input logic [23:0] q);
    cmd(8'h31);
    stat(3'b000);
    wait_rb();
    stat(3'b110);
    chk("out_row", out_row_o, q);
    cmd(8'h3F);
    stat(3'b000);
    wait_rb();
    stat(3'b111);
    chk("out_col", out_col_o, 0);
    chk("out_row", out_row_o, q + 24'h000001);
  endtask
  task automatic pick(input logic [23:0] row, input logic [0:0] pl);
    i_nprs_host_model.op5(8'h06, 16'h0000, row, 8'hE0);
    chk("out_plane", out_plane_o, pl);
    i_nprs_host_model.rel();
  endtask
  task automatic t_multi();
    i_nprs_host_model.op5(8'h00, 16'h0000, 24'h000501, 8'h32);
    i_nprs_host_model.op5(8'h00, 16'h0000, 24'h000600, 8'h30);
    stat(3'b000);
    wait_rb();
    stat(3'b111);
    pick(24'h000501, 1'b1);
    chk("out_row", out_row_o, 24'h000501);
    pick(24'h000600, 1'b0);
    chk("out_row", out_row_o, 24'h000600);
    cmd(8'h31);
    wait_rb();
    stat(3'b110);
    pick(24'h000501, 1'b1);
    chk("out_row", out_row_o, 24'h000501);
    cmd(8'h3F);
    wait_rb();
    stat(3'b111);
    pick(24'h000501, 1'b1);
    chk("out_row", out_row_o, 24'h000502);
  endtask
  task automatic t_abort();
    i_nprs_host_model.op5(8'h00, 16'h0000, 24'h000700, 8'h30);
    cmd(8'hFF);
    chk("reject", cmd_reject_o, 0);
    wait_rb();
    stat(3'b111);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard well above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      test_done();
    end
  end
  // main sequence
  initial begin
    reset_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_page();
    t_rand(24'h000300, 24'h000200);
    t_col();
    t_rand(24'h000400, 24'h000300);
    t_seq_last(24'h000400);
    t_multi();
    t_abort();
    test_done();
  end
endmodule

/* File: verification/nprs_host_model.sv */
// Purpose: host flash controller issuing command and address bytes
// Assumes: bytes launched on the falling edge, taken on the next rising edge
// Notes:   a released bus shows the inverted last byte, so stale data never matches
`timescale 1ns/1ns
module nprs_host_model (
  // clock
  input  logic       clk_i,
  // host bus cycles
  output logic       cmd_we_o,
  output logic       addr_we_o,
  output logic [7:0] dq_o
);
  // idle bus at time zero
  initial begin
    cmd_we_o  = 1'b0;
    addr_we_o = 1'b0;
    dq_o      = 8'h00;
  end
  // one byte held for a full clock
  task automatic put(input logic c, input logic [7:0] b);
    @(negedge clk_i);
    cmd_we_o  = c;
    addr_we_o = !c;
    dq_o      = b;
  endtask
  // release between operations
  task automatic rel();
    @(negedge clk_i);
    cmd_we_o  = 1'b0;
    addr_we_o = 1'b0;
    dq_o      = ~dq_o;
  endtask
  // opening command, column low first, row low first, confirm
  task automatic op5(input logic [7:0] c0, input logic [15:0] col, input logic [23:0] row, input logic [7:0] c1);
    put(1'b1, c0);
    put(1'b0, col[7:0]);
    put(1'b0, col[15:8]);
    put(1'b0, row[7:0]);
    put(1'b0, row[15:8]);
    put(1'b0, row[23:16]);
    put(1'b1, c1);
    rel();
  endtask
  // single command byte; callers wait out busy first except for status, reset or the refused 05h
  task automatic cmd1(input logic [7:0] c);
    put(1'b1, c);
    rel();
  endtask
  // column change; no data is requested, so the setup time is trivially met
  task automatic col2(input logic [15:0] col);
    put(1'b1, 8'h05);
    put(1'b0, col[7:0]);
    put(1'b0, col[15:8]);
    put(1'b1, 8'hE0);
    rel();
  endtask
endmodule

/* File: verification/nprs_read_seq_sva.sv */
// Purpose: port-level checks of the read sequencer
// Assumes: one byte per strobe, consecutive strobes for one operation
// Notes:   busy length is checked as a lower bound only
`timescale 1ns/1ns
module nprs_read_seq_sva #(
  parameter PLANE_W       = 1,
  parameter COL_W         = 16,
  parameter CACHE_BUSY_CY = 3
) (
  // clock and reset
  input logic               clk_i,
  input logic               reset_n_i,
  // host bytes
  input logic               cmd_we_i,
  input logic               addr_we_i,
  input logic [7:0]         dq_i,
  // status and output path
  input logic               ready_busy_n_o,
  input logic               lun_ready_o,
  input logic               array_ready_bit_o,
  input logic               data_out_en_o,
  input logic               status_out_en_o,
  input logic [PLANE_W-1:0] out_plane_o,
  input logic [COL_W-1:0]   out_col_o,
  input logic               cmd_reject_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] low_cnt;
  logic       abort_seen;
  logic       last_pend;
  logic       rb_q;
  wire        rdy  = ready_busy_n_o && lun_ready_o;
  wire        c_ok = cmd_we_i && (dq_i == 8'h70 || dq_i == 8'h78 || dq_i == 8'hFF || dq_i == 8'hFC);
  // busy bookkeeping; a reset command legally cuts a busy period short
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt    <= 8'h00;
      abort_seen <= 1'b0;
      last_pend  <= 1'b0;
      rb_q       <= 1'b1;
    end else begin
      low_cnt    <= ready_busy_n_o ? 8'h00 : low_cnt + 8'h01;
      abort_seen <= !ready_busy_n_o && (abort_seen || (c_ok && dq_i[7:4] == 4'hF));
      rb_q       <= ready_busy_n_o;
      if (cmd_we_i && dq_i == 8'h3F && rdy) begin
        last_pend <= 1'b1;
      end else if (ready_busy_n_o && !rb_q) begin
        last_pend <= 1'b0;
      end
    end
  end
  sequence s_cache;
    cmd_we_i && (dq_i == 8'h31 || dq_i == 8'h3F) && rdy;
  endsequence
  sequence s_page;
    cmd_we_i && dq_i == 8'h00 && rdy && array_ready_bit_o ##1 addr_we_i [*5] ##1 cmd_we_i && dq_i == 8'h30;
  endsequence
  sequence s_col;
    cmd_we_i && dq_i == 8'h05 && rdy ##1 addr_we_i [*2] ##1 cmd_we_i && dq_i == 8'hE0;
  endsequence
  sequence s_plane;
    cmd_we_i && dq_i == 8'h06 && rdy ##1 addr_we_i [*5] ##1 cmd_we_i && dq_i == 8'hE0;
  endsequence
  a_cache_busy: assert property (s_cache |=> !ready_busy_n_o && !lun_ready_o && !array_ready_bit_o)
    else $error("cache command did not raise busy");
  a_busy_len: assert property ($rose(ready_busy_n_o) && !abort_seen |-> low_cnt >= CACHE_BUSY_CY)
    else $error("busy period too short");
  a_cache_end: assert property ($rose(ready_busy_n_o) && !array_ready_bit_o |-> lun_ready_o && out_col_o == '0)
    else $error("cache ready state wrong");
  a_last_ready: assert property ($rose(ready_busy_n_o) && last_pend && !abort_seen |->
    array_ready_bit_o && lun_ready_o && out_col_o == '0)
    else $error("cache read end not fully ready");
  a_page_busy: assert property (s_page |=> !ready_busy_n_o && !array_ready_bit_o && data_out_en_o)
    else $error("page read did not start");
  a_busy_refuse: assert property ((cmd_we_i && !c_ok || addr_we_i) && !ready_busy_n_o |=>
    cmd_reject_o && $stable(out_col_o) && $stable(out_plane_o))
    else $error("byte during busy not refused");
  a_col_move: assert property (s_col |=> out_col_o == {$past(dq_i, 2), $past(dq_i, 3)} && data_out_en_o)
    else $error("column change wrong");
  a_plane_pick: assert property (s_plane |=> out_plane_o == $past(dq_i[PLANE_W-1:0], 4))
    else $error("plane select wrong");
  a_status_on: assert property (cmd_we_i && (dq_i == 8'h70 || dq_i == 8'h78) |=> status_out_en_o)
    else $error("status output not entered");
  a_read_mode: assert property (cmd_we_i && dq_i == 8'h00 && status_out_en_o && rdy |=>
    !status_out_en_o && data_out_en_o)
    else $error("read mode did not resume data");
endmodule
bind nprs_read_seq nprs_read_seq_sva #(.PLANE_W(PLANE_W), .COL_W(COL_W), .CACHE_BUSY_CY(CACHE_BUSY_CY)) i_sva (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_we_i(cmd_we_i), .addr_we_i(addr_we_i), .dq_i(dq_i),
  .ready_busy_n_o(ready_busy_n_o), .lun_ready_o(lun_ready_o), .array_ready_bit_o(array_ready_bit_o),
  .data_out_en_o(data_out_en_o), .status_out_en_o(status_out_en_o), .out_plane_o(out_plane_o),
  .out_col_o(out_col_o), .cmd_reject_o(cmd_reject_o));
